// File: bench/scu_peer.sv
// Purpose: Serial peer that drives the receive pin with asynchronous frames.
// Assumes: Base divider 0, so one bit lasts BIT_CLKS system clocks.
// Notes:   Line idles at mark level 1 between frames.
`timescale 1ns/10ps
module scu_peer #(
    parameter int BIT_CLKS = 16
) (
    input  wire logic clock,
    output logic      rxd
);
    // Idle mark level from time zero
    initial begin
        rxd = 1'b1;
    end

    // Start bit, eight data bits LSB first, stop bit of chosen level
    task automatic send(input logic [7:0] data, input logic stop);
        logic [9:0] frame;
        int         i;
        frame = {stop, data, 1'b0};
        for (i = 0; i < 10; i++) begin
            rxd <= frame[i];
            repeat (BIT_CLKS) @(posedge clock);
        end
        rxd <= 1'b1;
    endtask

    // Holds the line at a fixed level, low for a break
    task automatic level(input logic v);
        rxd <= v;
    endtask
endmodule

// File: bench/tb_top.sv
// Purpose: Self-checking bench for serial unit flags, requests and errors.
// Assumes: Baud divider 0, so a bit lasts 16 clocks.
// Notes:   External clock pin held high; sync receive timing is not exercised.
`timescale 1ns/10ps
`include "scu_map.svh"
module tb_top import scu_pkg::*;;
    logic       clock = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0, standby = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic       rxd, txd, txd_oe, sck_out, sck_oe, sck_in = 1'b1; // Held high
    logic       rx_error_irq, rx_full_irq, tx_empty_irq, tx_done_irq, irq_any;
    logic [1:0] irq_top;
    int         fails = 0, n_tests = 0, cycles = 0;

    scu_top u_scu_top (.clock(clock), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .standby(standby), .rxd(rxd), .txd(txd),
        .txd_oe(txd_oe), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
        .rx_error_irq(rx_error_irq), .rx_full_irq(rx_full_irq),
        .tx_empty_irq(tx_empty_irq), .tx_done_irq(tx_done_irq),
        .irq_any(irq_any), .irq_top(irq_top));
    scu_peer u_scu_peer (.clock(clock), .rxd(rxd));

    // Clock at 50 MHz
    initial begin
        forever #10 clock = ~clock;
    end

    // Hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fails = fails + 1;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Bus cycles: entered just after a rising edge
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge clock);
    endtask

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd_reg(a, d);
        chk(d, exp);
    endtask

    // Polls flags until the masked value matches, bounded
    task automatic wait_fl(input logic [7:0] m, input logic [7:0] v);
        logic [7:0] d;
        int         k;
        for (k = 0; k < 200; k++) begin
            rd_reg(`SCU_A_FLAGS, d);
            if ((d & m) === v)
                break;
        end
    endtask

    // Request lines in order error, full, empty, done, then the winner
    task automatic irqs(input logic [3:0] e, input logic [1:0] top);
        @(negedge clock);
        chk({4'h0, rx_error_irq, rx_full_irq, tx_empty_irq, tx_done_irq},
            {4'h0, e});
        chk({irq_any, 5'h0, irq_top}, {|e, 5'h0, top});
        @(posedge clock);
    endtask

    // Captures start, data LSB first and stop at mid-bit on falling edges
    // Lead: clocks from the first low seen to the middle of the start bit
    task automatic cap_tx(input logic [7:0] exp, input int lead);
        logic [9:0] d;
        int         k;
        @(negedge clock);
        for (k = 0; k < 400 && txd !== 1'b0; k++)
            @(negedge clock);
        for (k = 0; k < 10; k++) begin
            repeat (k == 0 ? lead : 16) @(negedge clock);
            d[k] = txd;
        end
        chk({d[9], 6'h0, d[0]}, 8'h80);
        chk(d[8:1], exp);
        @(posedge clock);
    endtask

    task automatic t_reset_irq();
        rd_chk(`SCU_A_FLAGS, 8'h84);
        rd_chk(`SCU_A_BAUD, `SCU_BAUD_RST);
        rd_chk(3'h6, 8'h00);
        wr_reg(`SCU_A_BAUD, 8'h00);
        wr_reg(`SCU_A_CTRL, 8'h04);
        irqs(4'h1, 2'h3);
        wr_reg(`SCU_A_CTRL, 8'h84);
        irqs(4'h3, 2'h2);
        wr_reg(`SCU_A_CTRL, 8'h00);
        irqs(4'h0, 2'h3);
    endtask

    task automatic t_tx();
        wr_reg(`SCU_A_CTRL, 8'h20);
        wr_reg(`SCU_A_TXH, 8'h5a);
        rd_chk(`SCU_A_FLAGS, 8'h80);
        wr_reg(`SCU_A_TXH, 8'h33);
        wr_reg(`SCU_A_TXH, 8'hc6);
        rd_chk(`SCU_A_FLAGS, 8'h00);
        cap_tx(8'h5a, 0);
        cap_tx(8'hc6, 8);
        wait_fl(8'h84, 8'h84);
        rd_chk(`SCU_A_FLAGS, 8'h84);
        wr_reg(`SCU_A_TXH, 8'hf0);
        repeat (60) @(posedge clock);
        wr_reg(`SCU_A_CTRL, 8'h00);
        @(negedge clock);
        chk({6'h0, txd_oe, txd}, 8'h01);
        @(posedge clock);
        rd_chk(`SCU_A_FLAGS, 8'h84);
    endtask

    task automatic t_rx();
        wr_reg(`SCU_A_CTRL, 8'h50);
        u_scu_peer.send(8'ha5, 1'b1);
        wait_fl(8'h40, 8'h40);
        irqs(4'h4, 2'h1);
        rd_chk(`SCU_A_RXH, 8'ha5);
        u_scu_peer.send(8'h3c, 1'b1);
        wait_fl(8'h20, 8'h20);
        rd_chk(`SCU_A_FLAGS, 8'he4);
        rd_chk(`SCU_A_RXH, 8'ha5);
        irqs(4'hc, 2'h0);
        wr_reg(`SCU_A_FLAGS, 8'h9f);
        u_scu_peer.send(8'h96, 1'b0);
        wait_fl(8'h10, 8'h10);
        rd_chk(`SCU_A_FLAGS, 8'h94);
        rd_chk(`SCU_A_RXH, 8'h96);
        wr_reg(`SCU_A_CTRL, 8'h40);
        rd_chk(`SCU_A_FLAGS, 8'h94);
        // Even parity on; the peer's last bit becomes a wrong parity bit
        wr_reg(`SCU_A_FMT, 8'h20);
        wr_reg(`SCU_A_FLAGS, 8'hef);
        wr_reg(`SCU_A_CTRL, 8'h50);
        u_scu_peer.send(8'h01, 1'b0);
        wait_fl(8'h08, 8'h08);
        rd_chk(`SCU_A_FLAGS, 8'h8c);
        rd_chk(`SCU_A_RXH, 8'h01);
        irqs(4'h8, 2'h0);
        wr_reg(`SCU_A_FMT, 8'h00);
        wr_reg(`SCU_A_FLAGS, 8'hf7);
    endtask

    task automatic t_break_sync();
        wr_reg(`SCU_A_CTRL, 8'h50);
        u_scu_peer.level(1'b0);
        wr_reg(`SCU_A_FLAGS, 8'hef);
        wait_fl(8'h10, 8'h10);
        rd_chk(`SCU_A_FLAGS, 8'h94);
        wr_reg(`SCU_A_FLAGS, 8'hef);
        wait_fl(8'h10, 8'h10);
        rd_chk(`SCU_A_FLAGS, 8'h94);
        u_scu_peer.level(1'b1);
        repeat (200) @(posedge clock);
        wr_reg(`SCU_A_CTRL, 8'h00);
        wr_reg(`SCU_A_FMT, 8'h80);
        wr_reg(`SCU_A_CTRL, 8'h21);
        wr_reg(`SCU_A_TXH, 8'h11);
        repeat (40) @(posedge clock);
        rd_chk(`SCU_A_FLAGS, 8'h10);
        wr_reg(`SCU_A_FLAGS, 8'hc7);
        wait_fl(8'h80, 8'h80);
        rd_chk(`SCU_A_FLAGS, 8'h80);
    endtask

    // A byte left pending while busy proves standby forces the empty flag
    task automatic t_standby();
        wr_reg(`SCU_A_CTRL, 8'ha1);
        wr_reg(`SCU_A_TXH, 8'h22);
        rd_chk(`SCU_A_FLAGS, 8'h00);
        standby <= 1'b1;
        repeat (20) @(posedge clock);
        standby <= 1'b0;
        @(posedge clock);
        rd_chk(`SCU_A_CTRL, 8'ha1);
        rd_chk(`SCU_A_FMT, 8'h80);
        rd_chk(`SCU_A_BAUD, 8'h00);
        irqs(4'h2, 2'h2);
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        t_reset_irq();
        t_tx();
        t_rx();
        t_break_sync();
        t_standby();
        end_sim();
    end
endmodule

// File: design/scu_bitclk.sv
// Purpose: Base clock tick at 16x the bit rate from a programmable divider.
// Assumes: Divider value is steady while running.
// Notes:   Tick is one cycle every divisor+1 clocks.
`timescale 1ns/10ps
module scu_bitclk #(
    parameter int DIV_W = 8
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             run,
    input  wire logic [DIV_W-1:0] divisor,
    output logic                  tick
);
    logic [DIV_W-1:0] cnt;

    // Tick on reaching the divisor
    assign tick = run && (cnt == divisor);

    // Free count, restarted when idle
    always_ff @(posedge clock) begin
        if (sys_rst || !run || tick) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end
endmodule

// File: design/scu_map.svh
// Purpose: Register offsets, field positions, reset values and counts of the serial unit.
// Assumes: 8-bit register port, 3-bit word address.
// Notes:   Definitions only.
// What this block does
// - Four separate interrupt request lines are driven.
// - Empty and done flags raise their requests.
// - Full flag and error flags raise requests.
// - Fixed priority: error, full, empty, done.
// - Hold-to-shift transfer sets the empty flag.
// - Hold writes always land, replacing pending byte.
// - Overrun discards the newly received byte.
// - Overrun keeps full; other errors still move data.
// - Break keeps receiver running, framing re-sets.
// - Clearing transmit enable aborts the transmitter.
// - Synchronous mode: receive errors block transmit start.
// - Clearing receive enable keeps error flags.
// - Asynchronous receive samples mid-bit at 16x.
// - External clock: late disable sets full, no move.
// - Internal clock: late disable sets full, no move.
// - Standby keeps setup; empty set if enabled.
// - Done and error requests gated by enables.
`ifndef SCU_MAP_SVH
`define SCU_MAP_SVH
// Word addresses
`define SCU_A_CTRL   3'h0
`define SCU_A_FLAGS  3'h1
`define SCU_A_FMT    3'h2
`define SCU_A_BAUD   3'h3
`define SCU_A_TXH    3'h4
`define SCU_A_RXH    3'h5
// Control word fields
`define SCU_C_TIE    7
`define SCU_C_RIE    6
`define SCU_C_TE     5
`define SCU_C_RE     4
`define SCU_C_TX_DONE_IRQ_EN   2
`define SCU_C_CKI    0
// Flags word fields
`define SCU_F_EMPTY  7
`define SCU_F_FULL   6
`define SCU_F_OVR    5
`define SCU_F_FERR   4
`define SCU_F_PERR   3
`define SCU_F_DONE   2
// Frame format fields
`define SCU_M_SYNC   7
`define SCU_M_PEN    5
`define SCU_M_ODD    4
// Reset values
`define SCU_CTRL_RST 8'h00
`define SCU_FMT_RST  8'h00
`define SCU_BAUD_RST 8'hff
// Counts
`define SCU_OVS      4'hf
`define SCU_MID      4'h7
`define SCU_LAST     3'h7
`define SCU_SETTLE   2'h3
`endif

// File: design/scu_pkg.sv
// Purpose: Types shared by the serial unit.
// Assumes: Nothing.
// Notes:   State enums carry no codes.
package scu_pkg;
    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} scu_tx_t;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_SETTLE} scu_rx_t;
    typedef enum logic [1:0] {IRQ_ERR, IRQ_FULL, IRQ_EMPTY, IRQ_DONE} scu_irq_t;
endpackage

// File: design/scu_top.sv
// Purpose: Serial unit flags, interrupt requests, error handling and bit engines.
// Assumes: Plain register port, 50 MHz clock, sys_rst synchronous active high.
// Notes:   Pins rxd and sck_in pass two flip-flops before use.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "scu_map.svh"
module scu_top import scu_pkg::*; #(
    parameter int DIV_W = 8
) (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       standby,
    input  wire logic       rxd,
    output logic            txd,
    output logic            txd_oe,
    input  wire logic       sck_in,
    output logic            sck_out,
    output logic            sck_oe,
    output logic            rx_error_irq,
    output logic            rx_full_irq,
    output logic            tx_empty_irq,
    output logic            tx_done_irq,
    output logic            irq_any,
    output logic      [1:0] irq_top
);
    if (DIV_W < 1 || DIV_W > 8) begin : g_chk
        $error("DIV_W must be 1 to 8");
    end

    logic [7:0] serial_ctrl_word, frame_format_word, baud_div_word;
    logic [7:0] tx_hold_buf, tx_shift_unit, rx_hold_buf, rx_shift_unit;
    logic       tx_buf_empty, rx_buf_full, overrun_flag;
    logic       frame_error_flag, parity_flag, tx_done_flag;
    logic       tx_on, rx_on, is_sync, int_clk, any_err, base_tick;
    logic       rx_in, sck_sync, sck_prev, sck_run, sck_rise, sck_fall;
    logic [3:0] sc, tcnt, rcnt;
    logic [2:0] tbit, rbit;
    logic [1:0] scnt;
    logic       tpar, fe_l, pe_l;
    logic       tx_step, tx_last, can_load, tx_load, tx_finish;
    logic       rx_sample, rx_done, rx_cut, w_flags, w_txh;
    logic [1:0] pin_raw, pin_sync;
    scu_tx_t    tx_state;
    scu_rx_t    rx_state;

    assign tx_on   = serial_ctrl_word[`SCU_C_TE];
    assign rx_on   = serial_ctrl_word[`SCU_C_RE];
    assign is_sync = frame_format_word[`SCU_M_SYNC];
    assign int_clk = serial_ctrl_word[`SCU_C_CKI];
    assign any_err = overrun_flag | frame_error_flag | parity_flag;
    assign w_flags = wr && (addr == `SCU_A_FLAGS);
    assign w_txh   = wr && (addr == `SCU_A_TXH);

    // Two-stage synchronisers for the receive and clock pins
    assign pin_raw = {sck_in, rxd};
    for (genvar gi = 0; gi < 2; gi++) begin : g_sync
        logic q1, q2;
        always_ff @(posedge clock) begin
            if (sys_rst) begin
                q1 <= 1'b1;
                q2 <= 1'b1;
            end else begin
                q1 <= pin_raw[gi];
                q2 <= q1;
            end
        end
        assign pin_sync[gi] = q2;
    end
    assign rx_in    = pin_sync[0];
    assign sck_sync = pin_sync[1];

    // Base clock at 16x the bit rate
    scu_bitclk #(.DIV_W(DIV_W)) u_bitclk (
        .clock   (clock),
        .sys_rst (sys_rst),
        .run     (tx_on | rx_on),
        .divisor (baud_div_word[DIV_W-1:0]),
        .tick    (base_tick)
    );

    // Setup registers: only sys_rst clears them, standby keeps them
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            serial_ctrl_word  <= `SCU_CTRL_RST;
            frame_format_word <= `SCU_FMT_RST;
            baud_div_word     <= `SCU_BAUD_RST;
        end else if (wr) begin
            if (addr == `SCU_A_CTRL) serial_ctrl_word <= wdata;
            if (addr == `SCU_A_FMT) frame_format_word <= wdata;
            if (addr == `SCU_A_BAUD) baud_div_word <= wdata;
        end
    end

    // Hold buffer takes every write, pending byte or not
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_hold_buf <= 8'h00;
        end else if (w_txh) begin
            tx_hold_buf <= wdata;
        end
    end

    // Synchronous clock: internal half periods of eight base ticks
    assign sck_run = is_sync && int_clk && !standby && (tx_state != TX_IDLE || rx_on);
    always_ff @(posedge clock) begin
        if (sys_rst || !sck_run) begin
            sc <= 4'h0;
        end else if (base_tick) begin
            sc <= sc + 4'h1;
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sck_prev <= 1'b1;
        end else begin
            sck_prev <= sck_sync;
        end
    end
    assign sck_rise = int_clk ? (sck_run && base_tick && sc == `SCU_MID)
                              : (sck_sync && !sck_prev);
    assign sck_fall = int_clk ? (sck_run && base_tick && sc == `SCU_OVS)
                              : (!sck_sync && sck_prev);
    assign sck_out  = !(sck_run && !sc[3]);
    assign sck_oe   = is_sync && int_clk && (tx_on || rx_on);

    // Transmit timing; sync mode holds off while receive errors stand
    assign tx_step   = is_sync ? sck_fall : (base_tick && tcnt == `SCU_OVS);
    assign can_load  = tx_on && !standby && !tx_buf_empty
                       && !(is_sync && any_err);
    assign tx_last   = tx_step && ((tx_state == TX_DATA && is_sync && tbit == `SCU_LAST)
                                   || tx_state == TX_STOP);
    assign tx_load   = can_load && (tx_state == TX_IDLE || tx_last);
    assign tx_finish = tx_last && !can_load;

    // Transmit engine; clearing enable resets it at once
    always_ff @(posedge clock) begin
        if (sys_rst || !tx_on || standby) begin
            tx_state      <= TX_IDLE;
            txd           <= 1'b1;
            tcnt          <= 4'h0;
            tbit          <= 3'h0;
            tpar          <= 1'b0;
            tx_shift_unit <= 8'h00;
        end else begin
            if (tx_state != TX_IDLE && base_tick) tcnt <= tcnt + 4'h1;
            if (tx_load) begin
                tx_shift_unit <= tx_hold_buf;
                tpar  <= ^tx_hold_buf ^ frame_format_word[`SCU_M_ODD];
                tbit  <= 3'h0;
                tcnt  <= 4'h0;
                tx_state <= is_sync ? TX_DATA : TX_START;
                txd   <= is_sync ? tx_hold_buf[0] : 1'b0;
            end else if (tx_finish) begin
                tx_state <= TX_IDLE; // sync mode keeps the last bit on the pin
            end else if (tx_step) begin
                case (tx_state)
                    TX_START: begin
                        tx_state <= TX_DATA;
                        txd <= tx_shift_unit[0];
                    end
                    TX_DATA: begin
                        if (tbit == `SCU_LAST) begin
                            tx_state <= frame_format_word[`SCU_M_PEN] ? TX_PAR : TX_STOP;
                            txd <= frame_format_word[`SCU_M_PEN] ? tpar : 1'b1;
                        end else begin
                            tbit <= tbit + 3'h1;
                            tx_shift_unit <= {1'b0, tx_shift_unit[7:1]};
                            txd <= tx_shift_unit[1];
                        end
                    end
                    TX_PAR: begin
                        tx_state <= TX_STOP;
                        txd <= 1'b1;
                    end
                    default: tx_state <= tx_state;
                endcase
            end
        end
    end
    assign txd_oe = tx_on;

    // Receive sampling: mid-bit in async, clock rise in sync
    assign rx_sample = is_sync ? sck_rise : (base_tick && rcnt == `SCU_OVS);
    assign rx_done   = rx_on && rx_state == RX_SETTLE && scnt == `SCU_SETTLE;
    assign rx_cut    = !rx_on && rx_state == RX_SETTLE;

    // Receive engine; keeps running through a break
    always_ff @(posedge clock) begin
        if (sys_rst || !rx_on || standby) begin
            rx_state      <= RX_IDLE;
            rcnt          <= 4'h0;
            rbit          <= 3'h0;
            scnt          <= 2'h0;
            fe_l          <= 1'b0;
            pe_l          <= 1'b0;
            rx_shift_unit <= 8'h00;
        end else begin
            if (base_tick) rcnt <= rcnt + 4'h1;
            case (rx_state)
                RX_IDLE: begin
                    fe_l <= 1'b0;
                    pe_l <= 1'b0;
                    rbit <= 3'h0;
                    scnt <= 2'h0;
                    rcnt <= 4'h0;
                    if (is_sync && !any_err) rx_state <= RX_DATA;
                    else if (!is_sync && !rx_in) rx_state <= RX_START;
                end
                RX_START: begin
                    if (base_tick && rcnt == `SCU_MID) begin
                        rcnt <= 4'h0;
                        rx_state <= rx_in ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_sample) begin
                        rx_shift_unit <= {rx_in, rx_shift_unit[7:1]};
                        rbit <= rbit + 3'h1;
                        if (rbit == `SCU_LAST) begin
                            if (is_sync) rx_state <= RX_SETTLE;
                            else if (frame_format_word[`SCU_M_PEN]) rx_state <= RX_PAR;
                            else rx_state <= RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (rx_sample) begin
                        pe_l <= rx_in ^ (^rx_shift_unit) ^ frame_format_word[`SCU_M_ODD];
                        rx_state <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_sample) begin
                        fe_l <= !rx_in;
                        rx_state <= RX_SETTLE;
                    end
                end
                RX_SETTLE: begin
                    scnt <= scnt + 2'h1;
                    if (rx_done) rx_state <= RX_IDLE;
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // Receive hold buffer: no move on overrun or late disable
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_hold_buf <= 8'h00;
        end else if (rx_done && !rx_buf_full) begin
            rx_hold_buf <= rx_shift_unit;
        end
    end

    // Transmit flags; hardware set wins over software clear
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_buf_empty <= 1'b1;
            tx_done_flag <= 1'b1;
        end else begin
            if (tx_load || !tx_on || (standby && serial_ctrl_word[`SCU_C_TIE]))
                tx_buf_empty <= 1'b1;
            else if (w_txh || (w_flags && !wdata[`SCU_F_EMPTY]))
                tx_buf_empty <= 1'b0;
            if (tx_finish || !tx_on)
                tx_done_flag <= 1'b1;
            else if (w_txh || tx_load || (w_flags && !wdata[`SCU_F_DONE]))
                tx_done_flag <= 1'b0;
        end
    end

    // Receive flags; disabling receive leaves the error flags alone, a late disable in settle sets full
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_buf_full      <= 1'b0;
            overrun_flag     <= 1'b0;
            frame_error_flag <= 1'b0;
            parity_flag      <= 1'b0;
        end else begin
            if (rx_cut || (rx_done && !fe_l && !pe_l)) rx_buf_full <= 1'b1;
            else if (w_flags && !wdata[`SCU_F_FULL]) rx_buf_full <= 1'b0;
            if (rx_done && rx_buf_full) overrun_flag <= 1'b1;
            else if (w_flags && !wdata[`SCU_F_OVR]) overrun_flag <= 1'b0;
            if (rx_done && fe_l) frame_error_flag <= 1'b1;
            else if (w_flags && !wdata[`SCU_F_FERR]) frame_error_flag <= 1'b0;
            if (rx_done && pe_l) parity_flag <= 1'b1;
            else if (w_flags && !wdata[`SCU_F_PERR]) parity_flag <= 1'b0;
        end
    end

    // Request lines stand while flag and enable both stand
    assign rx_error_irq = serial_ctrl_word[`SCU_C_RIE] && any_err;
    assign rx_full_irq  = serial_ctrl_word[`SCU_C_RIE] && rx_buf_full;
    assign tx_empty_irq = serial_ctrl_word[`SCU_C_TIE] && tx_buf_empty;
    assign tx_done_irq  = serial_ctrl_word[`SCU_C_TX_DONE_IRQ_EN] && tx_done_flag;
    assign irq_any      = rx_error_irq | rx_full_irq | tx_empty_irq | tx_done_irq;

    // Highest pending source, error first
    always_comb begin
        if (rx_error_irq) irq_top = IRQ_ERR;
        else if (rx_full_irq) irq_top = IRQ_FULL;
        else if (tx_empty_irq) irq_top = IRQ_EMPTY;
        else irq_top = IRQ_DONE;
    end

    // Read data one cycle after the strobe, zero when unmapped
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                `SCU_A_CTRL:  rdata <= serial_ctrl_word;
                `SCU_A_FLAGS: rdata <= {tx_buf_empty, rx_buf_full, overrun_flag,
                                        frame_error_flag, parity_flag, tx_done_flag, 2'h0};
                `SCU_A_FMT:   rdata <= frame_format_word;
                `SCU_A_BAUD:  rdata <= baud_div_word;
                `SCU_A_TXH:   rdata <= tx_hold_buf;
                `SCU_A_RXH:   rdata <= rx_hold_buf;
                default:      rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // Checks on the flag and engine behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    empty_on_load_a: assert property (tx_load |=> tx_buf_empty)
        else $error("empty flag not set on load");
    hold_overwrite_a: assert property (w_txh |=> tx_hold_buf == $past(wdata))
        else $error("hold write lost");
    overrun_discard_a: assert property (rx_done && rx_buf_full
        |=> overrun_flag && rx_buf_full && rx_hold_buf == $past(rx_hold_buf))
        else $error("overrun moved data");
    error_moves_a: assert property (rx_done && !rx_buf_full && fe_l
        |=> frame_error_flag && !rx_buf_full && rx_hold_buf == $past(rx_shift_unit))
        else $error("framing error handling wrong");
    tx_abort_a: assert property (!tx_on |=> tx_state == TX_IDLE && txd)
        else $error("transmit not aborted");
    sync_err_block_a: assert property (is_sync && any_err && tx_state == TX_IDLE
        |-> !tx_load)
        else $error("sync transmit started with error");
    rx_off_keep_a: assert property ($fell(rx_on) && !w_flags
        |=> $stable(overrun_flag) && $stable(frame_error_flag) && $stable(parity_flag))
        else $error("disable touched error flags");
    mid_sample_a: assert property (rx_state == RX_START && rx_on && !standby
        && !is_sync && base_tick && rcnt == `SCU_MID && !rx_in |=> rx_state == RX_DATA)
        else $error("start bit not taken mid-bit");
    cut_full_a: assert property (rx_cut
        |=> rx_buf_full && rx_hold_buf == $past(rx_hold_buf))
        else $error("late disable handling wrong");
    irq_order_a: assert property ((rx_error_irq |-> irq_top == IRQ_ERR)
        and (!rx_error_irq && rx_full_irq |-> irq_top == IRQ_FULL))
        else $error("priority wrong");
    standby_empty_a: assert property (standby && serial_ctrl_word[`SCU_C_TIE]
        |=> tx_buf_empty)
        else $error("standby did not set empty");

    cover property (tx_finish);
    cover property (rx_done && rx_buf_full);
    cover property (rx_cut);
    cover property (rx_done && fe_l && !rx_buf_full);
endmodule
